// ---- hw/iosl_defines.vh ----
// Constants for the input line sampling and line passing block.
// Summary of operation
// - Sample enabled lines every interval when awake.
// - In sleep, stay awake until batch gathered.
// - Two analog lines, at most one sample/ms.
// - Received data updates only enabled outputs.
// - Channel n drives only output n.
// - Default: outputs unchanged, forward to host.
// - Only matching source address updates outputs.
// - Address FFFF accepts any sender.
// - Filter gates outputs, not reception.
// - Timeout returns output to idle; both PWM outputs share one timer.
// - Accepted packet restarts all output timers.
// - Digital input eight never drives outputs.
// - Sample interval counts in milliseconds.
// - Buffer batch, then send one packet.
// - Analog sample is 10 bits, right-justified.
`ifndef IOSL_DEFINES_VH
`define IOSL_DEFINES_VH
// ****************************************
// Timing
// ****************************************
`define IOSL_CLK_HZ          200000000
`define IOSL_MS_NS           1000000
`define IOSL_CLK_NS          5
`define IOSL_MS_CYC          (`IOSL_MS_NS / `IOSL_CLK_NS)
`define IOSL_TICK_W          18
// ****************************************
// Fields and values
// ****************************************
`define IOSL_ADDR_ANY        16'hFFFF
`define IOSL_ADC_W           10
`define IOSL_DIG_LINES       8
`define IOSL_PWM_N           2
`define IOSL_PWM_FULL        10'h3FF
`define IOSL_TMR_W           16
`endif

// ---- hw/iosl_out_timer.v ----
// Per-output timeout timer counting millisecond ticks.
`include "iosl_defines.vh"
module iosl_out_timer (
	// Clock and reset.
	input  wire                   clk,
	input  wire                   rst_b,
	// Control.
	input  wire                   ms_tick,
	input  wire                   restart,
	input  wire [`IOSL_TMR_W-1:0] timeout_ms,
	// Result.
	output reg                    expire
);
	reg [`IOSL_TMR_W-1:0] cnt_q; // Remaining milliseconds.
	reg                   run_q; // Timer armed.

	// A zero timeout disables the timer; restart reloads it.
	always @(posedge clk) begin
		if (!rst_b) begin
			cnt_q  <= {`IOSL_TMR_W{1'b0}};
			run_q  <= 1'b0;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (restart) begin
				cnt_q <= timeout_ms;
				run_q <= (timeout_ms != {`IOSL_TMR_W{1'b0}});
			end else if (run_q && ms_tick) begin
				if (cnt_q == {{(`IOSL_TMR_W-1){1'b0}}, 1'b1}) begin
					run_q  <= 1'b0;
					expire <= 1'b1;
				end
				cnt_q <= cnt_q - {{(`IOSL_TMR_W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // iosl_out_timer

// ---- hw/iosl_top.v ----
// Input line sampler and received line passing toward local outputs.
`include "iosl_defines.vh"
module iosl_top (
	// Clock and reset.
	input  wire                   clk,
	input  wire                   rst_b,
	// Configuration.
	input  wire [7:0]             sample_interval,
	input  wire [7:0]             samples_before_transmit,
	input  wire                   sleep_select,
	input  wire [15:0]            input_source_address,
	input  wire                   serial_forward_enable,
	input  wire [`IOSL_TMR_W-1:0] digital_output_timeout,
	input  wire [`IOSL_TMR_W-1:0] pwm_output_timeout,
	input  wire                   pwm_zero_config,
	input  wire                   pwm_one_config,
	input  wire [7:0]             digital_out_enable,
	input  wire [7:0]             digital_in_enable,
	input  wire [1:0]             analog_in_enable,
	// Local input pins, asynchronous.
	input  wire [8:0]             digital_line_in,
	// Local converter results.
	input  wire [19:0]            analog_in,
	// Sample stream toward the radio.
	output reg                    sample_valid,
	output reg  [8:0]             sample_digital,
	output reg  [19:0]            sample_analog,
	output reg                    batch_send,
	output reg                    stay_awake,
	// Received packet, one sample per strobe.
	input  wire                   rx_valid,
	input  wire [15:0]            rx_source,
	input  wire [15:0]            rx_channel_mask,
	input  wire [15:0]            rx_digital,
	input  wire [31:0]            rx_analog,
	// Toward the serial host.
	output reg                    host_forward,
	output reg  [15:0]            host_digital,
	output reg  [31:0]            host_analog,
	// Local outputs.
	output reg  [7:0]             digital_line_out,
	output wire                   pwm_output_zero,
	output wire                   pwm_output_one
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	reg [8:0] din_s1_q; // First stage, read only by second.
	reg [8:0] din_s2_q; // Settled inputs.

	// Two stages guard against metastable pin levels.
	always @(posedge clk) begin
		if (!rst_b) begin
			din_s1_q <= 9'h000;
			din_s2_q <= 9'h000;
		end else begin
			din_s1_q <= digital_line_in;
			din_s2_q <= din_s1_q;
		end
	end

	// ****************************************
	// Millisecond timebase
	// ****************************************
	reg [`IOSL_TICK_W-1:0] pre_q;  // Prescaler counter.
	reg                    tick_q; // One-cycle millisecond pulse.

	// Fixed 1 ms base caps the sample rate at 1 kHz.
	always @(posedge clk) begin
		if (!rst_b) begin
			pre_q  <= {`IOSL_TICK_W{1'b0}};
			tick_q <= 1'b0;
		end else if (pre_q == `IOSL_MS_CYC - 1) begin
			pre_q  <= {`IOSL_TICK_W{1'b0}};
			tick_q <= 1'b1;
		end else begin
			pre_q  <= pre_q + {{(`IOSL_TICK_W-1){1'b0}}, 1'b1};
			tick_q <= 1'b0;
		end
	end

	// ****************************************
	// Sampler
	// ****************************************
	reg [7:0] ivl_q;   // Milliseconds since last sample.
	reg [7:0] batch_q; // Samples buffered in this batch.
	wire      take;    // Sample this millisecond.
	wire      any_en;  // Some input enabled.

	assign any_en = (|digital_in_enable) | (|analog_in_enable);
	assign take   = tick_q && any_en && (sample_interval != 8'h00) &&
	                (ivl_q + 8'h01 >= sample_interval);

	// Interval counting and batch accounting; a zero interval stops sampling.
	always @(posedge clk) begin
		if (!rst_b) begin
			ivl_q          <= 8'h00;
			batch_q        <= 8'h00;
			sample_valid   <= 1'b0;
			sample_digital <= 9'h000;
			sample_analog  <= 20'h00000;
			batch_send     <= 1'b0;
			stay_awake     <= 1'b0;
		end else begin
			sample_valid <= 1'b0;
			batch_send   <= 1'b0;
			if (take) begin
				ivl_q          <= 8'h00;
				sample_valid   <= 1'b1;
				sample_digital <= din_s2_q & {1'b0, digital_in_enable};
				sample_analog  <= analog_in & {{10{analog_in_enable[1]}},
				                               {10{analog_in_enable[0]}}};
				if (batch_q + 8'h01 >= samples_before_transmit) begin
					batch_q    <= 8'h00;
					batch_send <= 1'b1;
				end else begin
					batch_q <= batch_q + 8'h01;
				end
			end else if (tick_q) begin
				ivl_q <= ivl_q + 8'h01;
			end
			// Held awake while a batch is incomplete.
			stay_awake <= sleep_select && (sample_interval != 8'h00) &&
			              !(take && batch_q + 8'h01 >= samples_before_transmit);
		end
	end

	// ****************************************
	// Receive filter and host forwarding
	// ****************************************
	wire addr_ok; // Sender may change outputs.
	wire accept;  // Packet updates outputs.

	assign addr_ok = (input_source_address == `IOSL_ADDR_ANY) ||
	                 (rx_source == input_source_address);
	assign accept  = rx_valid && addr_ok;

	// With serial_forward_enable set, every sample is offered to the host regardless of the filter.
	always @(posedge clk) begin
		if (!rst_b) begin
			host_forward <= 1'b0;
			host_digital <= 16'h0000;
			host_analog  <= 32'h00000000;
		end else begin
			host_forward <= rx_valid && serial_forward_enable;
			if (rx_valid) begin
				host_digital <= rx_digital;
				host_analog  <= rx_analog;
			end
		end
	end

	// ****************************************
	// Output timers
	// ****************************************
	wire [8:0] exp; // Expiry pulses: 0..7 digital, 8 PWM.

	genvar g;
	generate
		for (g = 0; g < 9; g = g + 1) begin : g_tmr
			iosl_out_timer u_tmr (
				.clk        (clk),
				.rst_b      (rst_b),
				.ms_tick    (tick_q),
				.restart    (accept),
				.timeout_ms ((g == 8) ? pwm_output_timeout : digital_output_timeout),
				.expire     (exp[g])
			);
		end
	endgenerate

	// ****************************************
	// Line passing to outputs
	// ****************************************
	reg [9:0] lvl0_q; // PWM zero level.
	reg [9:0] lvl1_q; // PWM one level.
	wire      pwm_upd0;
	wire      pwm_upd1;
	wire [7:0] dig_kept; // Digital outputs after this cycle's expiries.
	wire [7:0] dig_sel;  // Digital outputs this sample may change.

	// Expiry is applied first, so an accept in the same cycle rewrites the expired lines that it selects.
	assign dig_kept = digital_line_out & ~(exp[7:0] & digital_out_enable);
	assign dig_sel  = digital_out_enable & rx_channel_mask[7:0];

	// Analog data sits in the low ten bits of each 16-bit field.
	assign pwm_upd0 = accept && pwm_zero_config && rx_channel_mask[9];
	assign pwm_upd1 = accept && pwm_one_config && rx_channel_mask[10];

	// Updates need filter pass; bit 8 of the digital field is ignored.
	always @(posedge clk) begin
		if (!rst_b) begin
			digital_line_out <= 8'h00;
			lvl0_q           <= 10'h000;
			lvl1_q           <= 10'h000;
		end else begin
			if (accept) begin
				// Only lines 0..7 exist here, so line 8 never reaches an output.
				digital_line_out <= (dig_kept & ~dig_sel) |
				                    (rx_digital[7:0] & dig_sel);
			end else begin
				digital_line_out <= dig_kept;
			end
			if (pwm_upd0) begin
				lvl0_q <= rx_analog[9:0];
			end else if (exp[8]) begin
				lvl0_q <= 10'h000;
			end
			if (pwm_upd1) begin
				lvl1_q <= rx_analog[25:16];
			end else if (exp[8]) begin
				lvl1_q <= 10'h000;
			end
		end
	end

	// ****************************************
	// PWM generators
	// ****************************************
	reg [9:0] ramp_q; // Shared PWM ramp.
	reg       pwm_output_zero_q;
	reg       pwm1_q;

	// Full scale compares high on every ramp step.
	always @(posedge clk) begin
		if (!rst_b) begin
			ramp_q <= 10'h000;
			pwm_output_zero_q <= 1'b0;
			pwm1_q <= 1'b0;
		end else begin
			ramp_q <= (ramp_q == 10'h3FE) ? 10'h000 : ramp_q + 10'h001;
			pwm_output_zero_q <= (lvl0_q == `IOSL_PWM_FULL) || (ramp_q < lvl0_q);
			pwm1_q <= (lvl1_q == `IOSL_PWM_FULL) || (ramp_q < lvl1_q);
		end
	end

	assign pwm_output_zero = pwm_output_zero_q;
	assign pwm_output_one  = pwm1_q;
endmodule // iosl_top

// ---- dv/iosl_asserts.sv ----
// Checker for the received line passing path of the top module.
`include "iosl_defines.vh"
module iosl_checker (
	// Clock and reset.
	input wire                   clk,
	input wire                   rst_b,
	// Strobes.
	input wire                   rx_valid,
	input wire                   host_forward,
	input wire                   sample_valid,
	input wire                   batch_send,
	// Configuration.
	input wire                   serial_forward_enable,
	input wire                   pwm_zero_config,
	input wire [7:0]             digital_out_enable,
	input wire [15:0]            input_source_address,
	input wire [`IOSL_TMR_W-1:0] digital_output_timeout,
	input wire [`IOSL_TMR_W-1:0] pwm_output_timeout,
	// Received sample and results.
	input wire [15:0]            rx_source,
	input wire [15:0]            rx_channel_mask,
	input wire [15:0]            rx_digital,
	input wire [15:0]            host_digital,
	input wire [31:0]            rx_analog,
	input wire [7:0]             digital_line_out,
	input wire                   pwm_output_zero
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// A sample that passes the source filter; timers off so nothing else moves outputs.
	wire       acc = rx_valid &&
	                 (input_source_address == 16'hFFFF || rx_source == input_source_address);
	wire       tz  = digital_output_timeout == 16'h0000;
	wire [7:0] sel = digital_out_enable & rx_channel_mask[7:0];
	wire       p0  = acc && pwm_zero_config && rx_channel_mask[9] && pwm_output_timeout == 16'h0000;
	a_fwd_follows_rx: assert property (rx_valid && serial_forward_enable |=> host_forward)
		else $error("no forward after sample");
	a_fwd_when_off: assert property (!serial_forward_enable |=> !host_forward)
		else $error("forward while disabled");
	a_fwd_carries_data: assert property (
		host_forward |-> $past(rx_valid) && host_digital == $past(rx_digital))
		else $error("forward without matching sample");
	a_out_held: assert property (!acc && tz |=> $stable(digital_line_out))
		else $error("outputs moved without accepted sample");
	a_out_paired: assert property (
		acc && tz |=> digital_line_out ==
		(($past(digital_line_out) & ~$past(sel)) | ($past(rx_digital[7:0]) & $past(sel))))
		else $error("outputs not updated by pairs");
	a_pwm_full_high: assert property (
		p0 && rx_analog[9:0] == 10'h3FF ##1 (!rx_valid)[*4] |-> pwm_output_zero)
		else $error("full scale not high");
	a_pwm_zero_low: assert property (
		p0 && rx_analog[9:0] == 10'h000 ##1 (!rx_valid)[*4] |-> !pwm_output_zero)
		else $error("zero duty not low");
	a_sample_one_cycle: assert property (sample_valid |=> !sample_valid)
		else $error("sample strobe too long");
	a_batch_with_sample: assert property (batch_send |-> sample_valid)
		else $error("batch without sample");
	c_accept: cover property (acc);
	c_reject: cover property (rx_valid && !acc);
	c_pwm: cover property (p0);
endmodule // iosl_checker
bind iosl_top iosl_checker i_chk (.*);

// ---- dv/iosl_peer.sv ----
// Model of the remote peer whose samples reach the block.
module iosl_peer (
	// Clock.
	input  wire         clk,
	// Received sample toward the block.
	output logic        rx_valid,
	output logic [15:0] rx_source,
	output logic [15:0] rx_channel_mask,
	output logic [15:0] rx_digital,
	output logic [31:0] rx_analog
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_valid = 1'b0;
		{rx_source, rx_channel_mask, rx_digital, rx_analog} = 80'h0;
	end
	// One sample per strobe; repeated calls refresh the far outputs.
	// Lines are inverted after release so stale values never look valid.
	task automatic send(input logic [15:0] s, m, d, input logic [31:0] a, input bit last);
		{rx_source, rx_channel_mask, rx_digital, rx_analog} = {s, m, d, a};
		rx_valid = 1'b1;
		@(posedge clk);
		#1;
		if (last) begin
			rx_valid = 1'b0;
			{rx_source, rx_channel_mask, rx_digital, rx_analog} = ~{s, m, d, a};
		end
	endtask
endmodule // iosl_peer

// ---- dv/iosl_top_tb.sv ----
// Self-checking bench of the line passing block.
module iosl_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, fwd = 1, pz = 1, po = 1, slp = 0;
	logic [15:0] addr = 16'h5678;
	logic [7:0] si = 8'h14, sbt = 8'h05, oen = 8'h0F, din = 8'hFF;
	logic [1:0] aen = 2'h3;
	logic [8:0] dli = 9'h0AA;
	logic [19:0] ain = 20'h003FF;
	wire hf, p0, p1, rv;
	wire [15:0] rs, rm, rd, hd;
	wire [31:0] ra;
	wire [31:0] ha;
	wire [7:0] dlo;
	wire sv, bs, sa;
	wire [8:0] sd;
	wire [19:0] san;
	logic [15:0] dto = 16'h0000, pto = 16'h0000;
	int mismatches, checks_done, samples;
	// No sample may appear within this short run, far below one interval.
	always @(negedge clk) if (sv === 1'b1 || bs === 1'b1) samples++;
	always #2.5 clk = ~clk;
	iosl_peer i_peer (.clk(clk), .rx_valid(rv), .rx_source(rs), .rx_channel_mask(rm),
		.rx_digital(rd), .rx_analog(ra));
	iosl_top i_dut (.clk(clk), .rst_b(rst_b), .sample_interval(si),
		.samples_before_transmit(sbt), .sleep_select(slp), .input_source_address(addr),
		.serial_forward_enable(fwd), .digital_output_timeout(dto),
		.pwm_output_timeout(pto), .pwm_zero_config(pz), .pwm_one_config(po),
		.digital_out_enable(oen), .digital_in_enable(din), .analog_in_enable(aen),
		.digital_line_in(dli), .analog_in(ain), .sample_valid(sv), .sample_digital(sd),
		.sample_analog(san), .batch_send(bs), .stay_awake(sa), .rx_valid(rv), .rx_source(rs),
		.rx_channel_mask(rm), .rx_digital(rd), .rx_analog(ra), .host_forward(hf),
		.host_digital(hd), .host_analog(ha), .digital_line_out(dlo),
		.pwm_output_zero(p0), .pwm_output_one(p1));
	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic see(input logic [7:0] o, input logic f);
		chk("host_forward", {31'h0, f}, {31'h0, hf});
		chk("digital_line_out", {24'h0, o}, {24'h0, dlo});
	endtask
	// Watch both PWM pins for a stretch of cycles.
	task automatic pwm(input logic e0);
		repeat (3) @(posedge clk);
		for (int i = 0; i < 30; i++) begin
			#1;
			chk("pwm_zero", {31'h0, e0}, {31'h0, p0});
			chk("pwm_one", 32'h0, {31'h0, p1});
			@(posedge clk);
		end
		#1;
	endtask
	// Count high cycles of PWM zero over one full ramp period of 1023 clocks.
	task automatic duty(input int e);
		int n;
		n = 0;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 1023; i++) begin
			#1;
			if (p0 === 1'b1) n++;
			@(posedge clk);
		end
		#1;
		chk("pwm_zero_duty", e, n);
	endtask
	task automatic complete_run;
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst_b = 1;
		i_peer.send(16'h1111, 16'h00FF, 16'h01FF, 32'h02AA0155, 1);
		see(8'h00, 1);
		chk("host_digital", 32'h01FF, {16'h0, hd});
		chk("host_analog", 32'h02AA0155, ha);
		i_peer.send(16'h5678, 16'h00FF, 16'h01FF, 32'h0, 1);
		see(8'h0F, 1);
		i_peer.send(16'h5678, 16'h0100, 16'h0000, 32'h0, 1);
		see(8'h0F, 1);
		i_peer.send(16'h5678, 16'h0003, 16'h0005, 32'h0, 1);
		see(8'h0D, 1);
		addr = 16'hFFFF;
		fwd = 0;
		i_peer.send(16'h1111, 16'h00FF, 16'h0000, 32'h0, 1);
		see(8'h00, 0);
		i_peer.send(16'h2222, 16'h000F, 16'h0003, 32'h0, 0);
		i_peer.send(16'h3333, 16'h000F, 16'h000C, 32'h0, 1);
		see(8'h0C, 0);
		po = 0;
		i_peer.send(16'h1111, 16'h0600, 16'h0, 32'h03FF03FF, 1);
		pwm(1);
		i_peer.send(16'h1111, 16'h0200, 16'h0, 32'h0, 1);
		pwm(0);
		i_peer.send(16'h1111, 16'h0200, 16'h0, 32'h00000200, 1);
		duty(512);
		chk("stay_awake", 32'h0, {31'h0, sa});
		slp = 1;
		@(posedge clk);
		#1;
		chk("stay_awake", 32'h1, {31'h0, sa});
		si = 8'h00;
		@(posedge clk);
		#1;
		chk("stay_awake", 32'h0, {31'h0, sa});
		si = 8'h14;
		slp = 0;
		// A one millisecond timeout fires only on the next millisecond tick, which this run never reaches.
		dto = 16'h0001;
		i_peer.send(16'h1111, 16'h000F, 16'h000F, 32'h0, 1);
		see(8'h0F, 0);
		repeat (50) @(posedge clk);
		#1;
		chk("digital_line_out", 32'h0F, {24'h0, dlo});
		// Reset in mid-run clears outputs; the block then takes no sample for the rest of the run.
		rst_b = 0;
		@(posedge clk);
		#1;
		see(8'h00, 0);
		chk("pwm_zero", 32'h0, {31'h0, p0});
		rst_b = 1;
		i_peer.send(16'h1111, 16'h0001, 16'h0001, 32'h0, 1);
		see(8'h01, 0);
		chk("sample_count", 32'h0, samples);
		chk("sample_digital", 32'h0, {23'h0, sd});
		chk("sample_analog", 32'h0, {12'h0, san});
		complete_run();
	end
	initial begin
		#100000;
		mismatches++;
		complete_run();
	end
endmodule // iosl_top_tb
